/* hdl/sdm_pkg.sv */
// Constants shared by the burst engine and its array store.
// Assumes one rising-edge clock shared with the command source.
package sdm_pkg;

    // Geometry of the array
    localparam int BANK_W = 2;
    localparam int NBANK  = 4;
    localparam int ROW_W  = 11;
    localparam int COL_W  = 8;
    localparam int DATA_W = 32;
    localparam int BYTES  = 4;

    // Address bit that carries the auto precharge choice
    localparam int AUTO_PRECHARGE_ADDRESS_BIT = 10;

    // Command codes as {ras_b, cas_b, we_b} with cs_b low
    localparam logic [2:0] CMD_ACTIVE    = 3'h3;
    localparam logic [2:0] CMD_READ      = 3'h5;
    localparam logic [2:0] CMD_WRITE     = 3'h4;
    localparam logic [2:0] CMD_TERMINATE = 3'h6;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;

    // Column read latency settings
    localparam logic [1:0] LAT_ONE = 2'h1;
    localparam logic [1:0] LAT_TWO = 2'h2;

    // Burst length codes
    localparam logic [2:0] BL_ONE   = 3'h0;
    localparam logic [2:0] BL_TWO   = 3'h1;
    localparam logic [2:0] BL_FOUR  = 3'h2;
    localparam logic [2:0] BL_EIGHT = 3'h3;
    localparam logic [2:0] BL_PAGE  = 3'h7;

    // Reset values
    localparam logic [BYTES-1:0] RST_MASK = 4'hF;
    localparam logic [NBANK-1:0] RST_OPEN = 4'h0;

endpackage

/* hdl/sdm_store.sv */
// Cell array of the device: byte-maskable write, combinational read.
// Assumes the engine presents at most one write per clock edge.
`timescale 1ns/10ps
`default_nettype none
module sdm_store
    import sdm_pkg::*;
#(
    parameter int ADDR_W = BANK_W + ROW_W + COL_W
) (
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [BYTES-1:0]  wr_be,
    input  wire logic [DATA_W-1:0] wr_data
);

    logic [DATA_W-1:0] cells [2**ADDR_W];
    logic [DATA_W-1:0] old_q;
    logic [DATA_W-1:0] merged;

    // Read is combinational so the engine can register it at once
    assign rd_data = cells[rd_addr];
    assign old_q   = cells[wr_addr];

    // One lane per byte; a cleared enable keeps the stored byte.
    // Lanes merge into one word so that one process owns the array.
    for (genvar b = 0; b < BYTES; b++) begin : g_lane
        assign merged[8*b +: 8] = wr_be[b] ? wr_data[8*b +: 8]
                                           : old_q[8*b +: 8];
    end

    // Whole-word write back of the merged lanes
    always_ff @(posedge clk) begin
        if (|wr_be) begin
            cells[wr_addr] <= merged;
        end
    end

endmodule
`default_nettype wire

/* hdl/sdm_burst_engine.sv */
// Read and write burst engine of a four-bank synchronous DRAM.
// Assumes commands, mask and data come from logic on clk, so no
// synchroniser is used; the controller keeps its own timing rules.
`timescale 1ns/10ps
`default_nettype none
module sdm_burst_engine
    import sdm_pkg::*;
#(
    parameter int ROW_KEEP = ROW_W
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              cs_b,
    input  wire logic              ras_b,
    input  wire logic              cas_b,
    input  wire logic              we_b,
    input  wire logic [BANK_W-1:0] ba,
    input  wire logic [ROW_W-1:0]  addr,
    input  wire logic [BYTES-1:0]  dqm,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic      [BYTES-1:0]  dq_oe,
    input  wire logic [1:0]        column_read_latency,
    input  wire logic [2:0]        burst_length_code,
    output logic      [NBANK-1:0]  bank_open
);

    if (ROW_KEEP < 1 || ROW_KEEP > ROW_W) begin : g_bad_rows
        $error("ROW_KEEP must lie between 1 and the row width");
    end

    localparam int MA_W = BANK_W + ROW_KEEP + COL_W;

    typedef struct packed {
        logic                          rd_act;
        logic                          rd_full;
        logic                          rd_ap;
        logic [BANK_W-1:0]             rd_bank;
        logic [COL_W-1:0]              rd_col;
        logic [COL_W-1:0]              rd_left;
        logic [COL_W-1:0]              rd_mask;
        logic                          wr_act;
        logic                          wr_full;
        logic                          wr_ap;
        logic [BANK_W-1:0]             wr_bank;
        logic [COL_W-1:0]              wr_col;
        logic [COL_W-1:0]              wr_left;
        logic [COL_W-1:0]              wr_mask;
        logic                          p1_v;
        logic [MA_W-1:0]               p1_a;
        logic                          p2_v;
        logic [MA_W-1:0]               p2_a;
        logic [BYTES-1:0]              dqm_d1;
        logic [DATA_W-1:0]             dq_out;
        logic [BYTES-1:0]              dq_oe;
        logic [NBANK-1:0]              open;
        logic [NBANK-1:0][ROW_KEEP-1:0] row;
    } sdm_state_s;

    sdm_state_s        s;
    sdm_state_s        next_s;
    logic [2:0]        cmd;
    logic              is_act;
    logic              is_rd;
    logic              is_wr;
    logic              is_bst;
    logic              is_pre;
    logic              ap_req;
    logic [COL_W-1:0]  bl_mask;
    logic              bl_full;
    logic              rd_pend;
    logic              wr_refuse;
    logic              iss_v;
    logic [MA_W-1:0]   iss_a;
    logic              src_v;
    logic [MA_W-1:0]   src_a;
    logic [MA_W-1:0]   wr_a;
    logic [BYTES-1:0]  wr_be;
    logic [DATA_W-1:0] mem_q;

    // Next column inside the burst block; a full mask walks the page
    function automatic logic [COL_W-1:0] next_col(
        input logic [COL_W-1:0] c,
        input logic [COL_W-1:0] m
    );
        logic [COL_W-1:0] inc;
        inc = c + COL_W'(1);
        return (c & ~m) | (inc & m);
    endfunction

    // Command decode; anything else counts as no operation
    assign cmd    = {ras_b, cas_b, we_b};
    assign is_act = !cs_b && cmd == CMD_ACTIVE;
    assign is_rd  = !cs_b && cmd == CMD_READ;
    assign is_wr  = !cs_b && cmd == CMD_WRITE;
    assign is_bst = !cs_b && cmd == CMD_TERMINATE;
    assign is_pre = !cs_b && cmd == CMD_PRECHARGE;
    assign ap_req = addr[AUTO_PRECHARGE_ADDRESS_BIT];

    // Burst length; reserved codes fall back to a single element
    always_comb begin
        bl_full = burst_length_code == BL_PAGE;
        unique case (burst_length_code)
            BL_ONE:   bl_mask = 8'h00;
            BL_TWO:   bl_mask = 8'h01;
            BL_FOUR:  bl_mask = 8'h03;
            BL_EIGHT: bl_mask = 8'h07;
            BL_PAGE:  bl_mask = 8'hFF;
            default:  bl_mask = 8'h00;
        endcase
    end

    // A WRITE over live read data needs the mask high the clock before
    assign rd_pend   = s.rd_act || s.p1_v || s.p2_v || (|s.dq_oe);
    assign wr_refuse = is_wr && rd_pend && s.dqm_d1 != RST_MASK;

    // Pick the issue stage that matches the programmed latency
    always_comb begin
        unique case (column_read_latency)
            LAT_ONE: begin
                src_v = iss_v;
                src_a = iss_a;
            end
            LAT_TWO: begin
                src_v = s.p1_v;
                src_a = s.p1_a;
            end
            default: begin
                src_v = s.p2_v;
                src_a = s.p2_a;
            end
        endcase
    end

    // Burst engines, read pipeline and bank bookkeeping
    always_comb begin
        next_s = s;
        iss_v  = 1'b0;
        iss_a  = '0;
        wr_a   = '0;
        wr_be  = '0;
        next_s.dqm_d1 = dqm;

        // Read side: a new READ always wins over a running burst
        if (is_rd) begin
            iss_v          = 1'b1;
            iss_a          = {ba, s.row[ba], addr[COL_W-1:0]};
            next_s.rd_act  = bl_full || bl_mask != 8'h00;
            next_s.rd_full = bl_full;
            next_s.rd_ap   = ap_req && !bl_full;
            next_s.rd_bank = ba;
            next_s.rd_mask = bl_mask;
            next_s.rd_left = bl_mask;
            next_s.rd_col  = next_col(addr[COL_W-1:0], bl_mask);
            if (ap_req && !bl_full && bl_mask == 8'h00) begin
                next_s.open[ba] = 1'b0;
            end
        end else if (is_wr || is_bst ||
                     (is_pre && (ap_req || ba == s.rd_bank))) begin
            next_s.rd_act = 1'b0;
        end else if (s.rd_act) begin
            iss_v         = 1'b1;
            iss_a         = {s.rd_bank, s.row[s.rd_bank], s.rd_col};
            next_s.rd_col = next_col(s.rd_col, s.rd_mask);
            if (!s.rd_full) begin
                next_s.rd_left = s.rd_left - COL_W'(1);
                if (s.rd_left == 8'h01) begin
                    next_s.rd_act = 1'b0;
                    if (s.rd_ap) begin
                        next_s.open[s.rd_bank] = 1'b0;
                    end
                end
            end
        end

        // Write side: data on the command edge belongs to that command
        if (is_wr && !wr_refuse) begin
            wr_a           = {ba, s.row[ba], addr[COL_W-1:0]};
            wr_be          = ~dqm;
            next_s.wr_act  = bl_full || bl_mask != 8'h00;
            next_s.wr_full = bl_full;
            next_s.wr_ap   = ap_req && !bl_full;
            next_s.wr_bank = ba;
            next_s.wr_mask = bl_mask;
            next_s.wr_left = bl_mask;
            next_s.wr_col  = next_col(addr[COL_W-1:0], bl_mask);
            if (ap_req && !bl_full && bl_mask == 8'h00) begin
                next_s.open[ba] = 1'b0;
            end
        end else if (is_wr || is_rd || is_bst || is_pre) begin
            next_s.wr_act = 1'b0;
        end else if (s.wr_act) begin
            wr_a          = {s.wr_bank, s.row[s.wr_bank], s.wr_col};
            wr_be         = ~dqm;
            next_s.wr_col = next_col(s.wr_col, s.wr_mask);
            if (!s.wr_full) begin
                next_s.wr_left = s.wr_left - COL_W'(1);
                if (s.wr_left == 8'h01) begin
                    next_s.wr_act = 1'b0;
                    if (s.wr_ap) begin
                        next_s.open[s.wr_bank] = 1'b0;
                    end
                end
            end
        end

        // Latency pipeline; a WRITE flushes every read in flight
        next_s.p1_v = iss_v && !is_wr;
        next_s.p1_a = iss_a;
        next_s.p2_v = s.p1_v && !is_wr;
        next_s.p2_a = s.p1_a;

        // Output stage: mask sampled one edge back gives two clocks
        next_s.dq_out = mem_q;
        if (src_v && !is_wr) begin
            next_s.dq_oe = ~s.dqm_d1;
        end else begin
            next_s.dq_oe = '0;
        end

        // Row opening and explicit precharge
        if (is_act) begin
            next_s.open[ba] = 1'b1;
            next_s.row[ba]  = addr[ROW_KEEP-1:0];
        end else if (is_pre) begin
            if (ap_req) begin
                next_s.open = RST_OPEN;
            end else begin
                next_s.open[ba] = 1'b0;
            end
        end
    end

    // Single state register; bus is released during reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s        <= '0;
            s.dqm_d1 <= RST_MASK;
            s.open   <= RST_OPEN;
        end else begin
            s <= next_s;
        end
    end

    assign dq_out    = s.dq_out;
    assign dq_oe     = s.dq_oe;
    assign bank_open = s.open;

    sdm_store #(
        .ADDR_W (MA_W)
    ) u_store (
        .clk     (clk),
        .rd_addr (src_a),
        .rd_data (mem_q),
        .wr_addr (wr_a),
        .wr_be   (wr_be),
        .wr_data (dq_in)
    );

    // Checks on the burst timing
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic no_cmd;
    assign no_cmd = !(is_act || is_rd || is_wr || is_bst || is_pre);

    rd_latency_a: assert property (
        is_rd && column_read_latency == LAT_TWO && dqm == 4'h0
        ##1 (!is_wr && column_read_latency == LAT_TWO)
        |=> dq_oe == 4'hF)
        else $error("read data not driven at latency two");
    rd_mask_a: assert property (
        $past(dqm, 2) == 4'hF |-> dq_oe == 4'h0)
        else $error("masked read byte was driven");
    wr_float_a: assert property (
        is_wr |=> dq_oe == 4'h0)
        else $error("bus driven after write command");
    rd_release_a: assert property (
        !s.rd_act && !s.p1_v && !s.p2_v && !is_rd |=> dq_oe == 4'h0)
        else $error("bus driven after read burst ended");
    rd_issue_a: assert property (
        is_rd && !is_wr |=> s.p1_v && s.p1_a[COL_W-1:0] ==
        $past(addr[COL_W-1:0]))
        else $error("read column not issued");
    page_wrap_a: assert property (
        s.rd_act && s.rd_full && s.rd_col == 8'hFF && no_cmd
        |=> s.rd_col == 8'h00)
        else $error("full page read failed to wrap");
    wr_capture_a: assert property (
        is_wr && !wr_refuse |-> wr_be == ~dqm &&
        wr_a[COL_W-1:0] == addr[COL_W-1:0])
        else $error("write data not taken on command edge");
    wr_idle_a: assert property (
        !s.wr_act && !is_wr |-> wr_be == 4'h0)
        else $error("data written outside a write burst");
    ap_close_a: assert property (
        s.rd_act && s.rd_ap && !s.rd_full && s.rd_left == 8'h01 &&
        no_cmd |=> !s.open[$past(s.rd_bank)])
        else $error("auto precharge did not close the row");
    pre_all_a: assert property (
        is_pre && ap_req |=> bank_open == 4'h0)
        else $error("precharge all left a bank open");
    pre_bank_a: assert property (
        is_pre && !ap_req |=> !bank_open[$past(ba)])
        else $error("precharge left its bank open");
    wr_drop_a: assert property (
        is_wr && rd_pend && $past(dqm) != 4'hF |-> wr_be == 4'h0)
        else $error("unmasked truncating write was stored");

    rd_lat3_c: cover property (
        is_rd && column_read_latency == 2'h3 ##3 dq_oe != 4'h0);
    rd_trunc_c: cover property (s.rd_act ##1 is_bst);
    rd_to_wr_c: cover property (is_rd ##[1:4] is_wr);
    wr_burst_c: cover property (is_wr ##1 s.wr_act);
    pre_all_c: cover property (is_pre && ap_req);

endmodule
`default_nettype wire

/* tb/sdm_ctrl_model.sv */
// Controller model: drives command, address, byte mask and write data.
// Assumes one issue call per cycle from a single bench process.
`timescale 1ns/10ps
`default_nettype none
module sdm_ctrl_model
    import sdm_pkg::*;
#(
    parameter int ACT_GAP = 3,
    parameter int PRE_GAP = 3
) (
    input  wire logic   clk,
    output logic        cs_b,
    output logic        ras_b,
    output logic        cas_b,
    output logic        we_b,
    output logic [1:0]  ba,
    output logic [10:0] addr,
    output logic [3:0]  dqm,
    output logic [31:0] dq_in
);
    int n = 0;
    int t_last = 0;
    int act_t [4] = '{default: -99};
    int pre_t [4] = '{default: -99};

    // At a falling edge this names the coming rising edge
    always @(posedge clk) begin
        n <= n + 1;
    end

    // Idle: deselected, all lines high
    initial begin
        {cs_b, ras_b, cas_b, we_b, ba, addr, dqm, dq_in} = '1;
    end

    // One command per cycle; pins change only after a falling edge
    task automatic issue(input logic [2:0] c, input logic [1:0] b,
            input logic [10:0] a, input logic [3:0] m,
            input logic [31:0] d, input bit drv);
        @(negedge clk);
        // Stall with no-ops until the row is ready or the bank recovered
        while ((c == CMD_READ || c == CMD_WRITE) && n - act_t[b] < ACT_GAP
               || c == CMD_ACTIVE && n - pre_t[b] < PRE_GAP) begin
            cs_b = 1'b1;
            dq_in = ~dq_in;
            @(negedge clk);
        end
        {ras_b, cas_b, we_b} = c;
        cs_b = (c == 3'h7);
        {ba, addr, dqm} = {b, a, m};
        // Drive only while writing; a released bus shows the inverse
        dq_in = drv ? d : ~dq_in;
        t_last = n;
        if (c == CMD_ACTIVE)
            act_t[b] = n;
        for (int i = 0; i < 4; i++)
            if (c == CMD_PRECHARGE && (a[10] || i == b))
                pre_t[i] = n;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* tb/sdram_read_write_bursts_test.sv */
// Bench: burst engine checked every cycle against a cycle-indexed model.
// Assumes the controller model issues one command per clock cycle.
`timescale 1ns/10ps
`default_nettype none
module sdram_read_write_bursts_test
    import sdm_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [1:0]  lat = 2'h2;
    logic [2:0]  blc = 3'h2;
    logic        cs_b, ras_b, cas_b, we_b;
    logic [1:0]  ba;
    logic [10:0] addr;
    logic [3:0]  dqm, dq_oe, bank_open;
    logic [31:0] dq_in, dq_out;
    logic [31:0] mem [int];
    bit          ev [4096];
    logic [31:0] ed [4096];
    logic [3:0]  dh [4096];
    logic [3:0]  op = 4'h0;
    logic [15:0] rnd = 16'h0060;
    logic [2:0]  codes [5] = '{3'h5, BL_ONE, BL_TWO, BL_FOUR, BL_EIGHT};
    int          n_fail = 0, comparisons = 0;
    int          cl = 2, bl = 4, wk = 99, wb, wc, wok;

    always #25 clk = ~clk;

    sdm_burst_engine #(.ROW_KEEP(2)) dut_u (.clk(clk), .rst_b(rst_b),
        .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .ba(ba),
        .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .column_read_latency(lat),
        .burst_length_code(blc), .bank_open(bank_open));
    sdm_ctrl_model ctrl_u (.clk(clk), .cs_b(cs_b), .ras_b(ras_b),
        .cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr), .dqm(dqm),
        .dq_in(dq_in));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Column of element k: wraps inside the block, full page at 255
    function automatic int colk(input int c, input int k);
        return (c & ~(bl - 1)) | ((c + k) & (bl - 1) & 255);
    endfunction

    task automatic cmp_bus(input logic [3:0] eo, input logic [31:0] e);
        logic [31:0] bm;
        bm = {{8{eo[3]}}, {8{eo[2]}}, {8{eo[1]}}, {8{eo[0]}}};
        comparisons++;
        if (dq_oe !== eo || (dq_out & bm) !== (e & bm)) begin
            n_fail++;
            $display("mismatch read bus expected %h/%h seen %h/%h",
                     eo, e & bm, dq_oe, dq_out & bm);
        end
    endtask

    // Looked at a little after the edge so the registers have landed
    task automatic cmp_open();
        #5;
        comparisons++;
        if (bank_open !== op) begin
            n_fail++;
            $display("mismatch bank_open expected %h seen %h", op, bank_open);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Static settings move only while the engine is idle
    task automatic cfg(input logic [1:0] l, input logic [2:0] c);
        @(negedge clk);
        // The pins keep the last mask this cycle; the model must see it
        dh[ctrl_u.n] = dqm;
        lat = l;
        blc = c;
        cl = l;
        bl = c == BL_PAGE ? 256 : (c < 4 ? 1 << c : 1);
    endtask

    // One cycle through the controller, then the model follows it
    task automatic go(input logic [2:0] c, input int b, input int a,
            input logic [3:0] m, input bit drv);
        int t;
        rnd = lfsr(rnd);
        ctrl_u.issue(c, 2'(b), 11'(a), m, {rnd, ~rnd}, drv);
        t = ctrl_u.t_last;
        dh[t] = m;
        if (c != 3'h7)
            wk = 99;
        if (c == CMD_READ || c == CMD_TERMINATE || c == CMD_PRECHARGE)
            for (int j = t + cl; j < t + 300; j++)
                ev[j] = 1'b0;
        // Capped so a full page only looks at columns already written
        if (c == CMD_READ)
            for (int k = 0; k < (bl > 8 ? 6 : bl); k++) begin
                ev[t + cl + k] = 1'b1;
                ed[t + cl + k] = mem[b * 256 + colk(a & 255, k)];
            end
        // A write after unmasked live read data is dropped whole
        if (c == CMD_WRITE) begin
            wok = 1;
            for (int j = t; j < t + 300; j++) begin
                wok &= !(ev[j] && dh[t - 1] !== 4'hF);
                ev[j] = ev[j] && j == t;
            end
            wb = b;
            wc = a & 255;
            wk = 0;
        end
        if (c == CMD_ACTIVE)
            op[b] = 1'b1;
        if (c == CMD_PRECHARGE)
            op = a[10] ? 4'h0 : op & ~(4'h1 << b);
        if ((c == CMD_READ || c == CMD_WRITE) && a[10] && bl < 256)
            op[b] = 1'b0;
        if (wk < bl && wok)
            for (int y = 0; y < 4; y++)
                if (!m[y])
                    mem[wb * 256 + colk(wc, wk)][8 * y +: 8] =
                        dq_in[8 * y +: 8];
        if (wk < bl)
            wk++;
    endtask

    task automatic idle(input int k);
        repeat (k) go(3'h7, 0, 0, 4'h0, 0);
    endtask

    task automatic wr(input int b, input int a, input int k, input bit r);
        go(CMD_WRITE, b, a, r ? rnd[3:0] : 4'h0, 1);
        repeat (k - 1) go(3'h7, 0, 0, r ? rnd[7:4] : 4'h0, 1);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    // What the controller samples at the coming edge, every cycle
    always @(negedge clk)
        cmp_bus(ev[ctrl_u.n] ? ~dh[ctrl_u.n - 2] : 4'h0,
                ed[ctrl_u.n]);

    // Hang guard
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial begin
        foreach (dh[i]) dh[i] = 4'hF;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        cmp_open();
        for (int b = 0; b < 4; b++)
            go(CMD_ACTIVE, b, 0, 4'h0, 0);
        idle(1);
        cmp_open();
        done("activate");
        cfg(2'h2, BL_EIGHT);
        for (int i = 0; i < 8; i++)
            wr(i / 2, (i % 2) * 8, 8, 0);
        cfg(2'h2, BL_FOUR);
        wr(0, 2, 2, 0);
        wr(1, 4, 4, 1);
        go(3'h7, 0, 0, 4'h0, 1);
        go(3'h7, 0, 0, 4'h0, 1);
        done("write");
        for (int l = 1; l < 4; l++) begin
            foreach (codes[i]) begin
                cfg(2'(l), codes[i]);
                go(CMD_READ, 0, int'(rnd[3:0]), 4'h0, 0);
                idle(12);
            end
            go(CMD_READ, 1, 0, 4'h0, 0);
            go(CMD_READ, 2, 5, 4'h0, 0);
            go(CMD_READ, 3, 9, 4'h0, 0);
            idle(14);
        end
        done("read");
        cfg(2'h3, BL_EIGHT);
        go(CMD_READ, 0, 0, 4'h0, 0);
        idle(2);
        go(CMD_TERMINATE, 0, 0, 4'h0, 0);
        idle(10);
        go(CMD_READ, 2, 0, 4'h0, 0);
        idle(1);
        go(CMD_PRECHARGE, 2, 0, 4'h0, 0);
        idle(10);
        cmp_open();
        go(CMD_ACTIVE, 2, 0, 4'h0, 0);
        idle(1);
        done("truncate");
        cfg(2'h2, BL_PAGE);
        wr(3, 254, 4, 0);
        go(CMD_TERMINATE, 3, 0, 4'h0, 1);
        go(CMD_READ, 3, 254, 4'h0, 0);
        idle(3);
        go(CMD_TERMINATE, 3, 0, 4'h0, 0);
        idle(6);
        done("page");
        cfg(2'h2, BL_TWO);
        go(CMD_READ, 1, 1024 + 2, 4'h0, 0);
        idle(6);
        wr(0, 1024 + 4, 2, 0);
        idle(4);
        cmp_open();
        done("auto precharge");
        cfg(2'h2, BL_EIGHT);
        for (int v = 0; v < 2; v++) begin
            go(CMD_READ, 2, 0, 4'h0, 0);
            go(3'h7, 0, 0, 4'h0, 0);
            go(3'h7, 0, 0, v ? 4'hF : 4'h0, 0);
            go(3'h7, 0, 0, v ? 4'hF : 4'h0, 0);
            wr(2, 0, 8, 0);
            go(CMD_READ, 2, 0, 4'h0, 0);
            idle(12);
        end
        cmp_open();
        go(CMD_PRECHARGE, 1, 1024, 4'h0, 0);
        cmp_open();
        done("turnaround");
        complete_run();
    end
endmodule
`default_nettype wire
